// >>> mdsl_slave.sv
// Purpose: management-data slave, standard and extended register access
// Assumes: REF_CLK 50 MHz, management clock from the far controller
// Notes:   management clock is oversampled, not used as a clock
`timescale 1ns/1ps
`include "mdsl_consts.svh"

// Function
// - A frame is 32 ones, start 01, two-bit opcode, five-bit phy and reg fields, turnaround, 16 data bits.
// - Opcode 10 with phy field bits 2 and 1 both set is an extended register read.
// - Opcode 01 with phy field bits 2 and 1 both set is an extended register write.
// - The extended address is phy bits 4, 3, 0 followed by the five reg field bits.
// - On a read the controller releases in the first turnaround bit and the device drives zero in the second.
// - An extended read returns the byte in the low data bits with the upper byte zero.
// - An extended write stores only the low data byte and ignores the upper byte.
// - Standard frames expose phy registers 0 to 5, 1d and 1f, sixteen bits each, per port.
// - Standard frames never reach the switch configuration registers.
// - Extended access reaches every switch register from 0 to 255.
// - Extended frames use the same timing and handshake as standard frames.
module mdsl_slave
  import mdsl_pkg::*;
(
  input  wire logic REF_CLK,
  input  wire logic RST,
  input  wire logic MDC,
  input  wire logic MDIO_I,
  output logic      MDIO_O,
  output logic      MDIO_OE,
  output logic      SW_WR_STB,
  output logic [7:0] SW_WR_ADDR,
  output mdsl_byte_t SW_WR_DATA
);

  mdsl_state_e state_r;
  logic [2:0]  mdc_s_r;
  logic [2:0]  dio_s_r;
  logic        mdc_lvl_r;
  logic        mdc_prev_r;
  logic        dio_lvl_r;
  logic        rise;
  logic        bit_in;
  logic [5:0]  ones_r;
  logic [3:0]  cnt_r;
  logic [10:0] hdr_r;
  logic [11:0] hdr_nxt;
  logic        rd_r;
  logic        ext_r;
  logic        hit_r;
  logic [7:0]  sw_addr_r;
  logic [5:0]  phy_idx_r;
  mdsl_word_t  sh_r;
  mdsl_word_t  wr_nxt;
  mdsl_byte_t  sw_rdata;
  mdsl_word_t  phy_rdata;
  logic        phy_we_r;
  mdsl_word_t  phy_wdata_r;
  logic [3:0]  slot_w;
  logic [4:0]  port_w;

  // maps a reg field onto one of eight slots per port
  function automatic logic [3:0] std_slot(input logic [4:0] ra);
    if (ra <= `MDSL_STD_LAST) begin
      std_slot = {1'b1, ra[2:0]};
    end else if (ra == `MDSL_REG_1D) begin
      std_slot = {1'b1, `MDSL_IDX_1D};
    end else if (ra == `MDSL_REG_1F) begin
      std_slot = {1'b1, `MDSL_IDX_1F};
    end else begin
      std_slot = 4'h0;
    end
  endfunction

  function automatic logic is_ext(input logic [1:0] op, input logic [4:0] pa);
    is_ext = (pa[2:1] == `MDSL_EXT_SEL) && (op == `MDSL_OP_RD || op == `MDSL_OP_WR);
  endfunction

  // three-stage sync, level accepted only when stages two and three agree
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      mdc_s_r    <= 3'h0;
      dio_s_r    <= 3'h7;
      mdc_lvl_r  <= 1'b0;
      mdc_prev_r <= 1'b0;
      dio_lvl_r  <= 1'b1;
    end else begin
      mdc_s_r    <= {mdc_s_r[1:0], MDC};
      dio_s_r    <= {dio_s_r[1:0], MDIO_I};
      mdc_prev_r <= mdc_lvl_r;
      if (mdc_s_r[1] == mdc_s_r[2]) begin
        mdc_lvl_r <= mdc_s_r[2];
      end
      if (dio_s_r[1] == dio_s_r[2]) begin
        dio_lvl_r <= dio_s_r[2];
      end
    end
  end

  assign rise    = mdc_lvl_r & ~mdc_prev_r;
  assign bit_in  = dio_lvl_r;
  assign hdr_nxt = {hdr_r, bit_in};
  assign wr_nxt  = {sh_r[14:0], bit_in};
  assign slot_w  = std_slot(hdr_nxt[4:0]);
  // only ports 1..5 are meaningful; others never hit, though some wrap into storage through the 3-bit index
  assign port_w  = hdr_nxt[9:5] - `MDSL_PORT_FIRST;

  // frame sequencing; ext and standard share every step
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_r <= MDSL_PRE;
      ones_r  <= 6'd0;
      cnt_r   <= 4'd0;
      hdr_r   <= 11'h0;
    end else if (rise) begin
      unique case (state_r)
        MDSL_PRE: begin
          if (bit_in) begin
            if (ones_r != `MDSL_PRE_ONES) begin
              ones_r <= ones_r + 6'd1;
            end
          end else begin
            ones_r <= 6'd0;
            if (ones_r == `MDSL_PRE_ONES) begin
              state_r <= MDSL_SOF;
            end
          end
        end
        MDSL_SOF: begin
          cnt_r   <= 4'd0;
          state_r <= bit_in ? MDSL_HDR : MDSL_PRE;
        end
        MDSL_HDR: begin
          hdr_r <= hdr_nxt[10:0];
          cnt_r <= cnt_r + 4'd1;
          if (cnt_r == `MDSL_HDR_LAST) begin
            cnt_r   <= 4'd0;
            state_r <= MDSL_TA;
          end
        end
        MDSL_TA: begin
          cnt_r <= cnt_r + 4'd1;
          if (cnt_r == `MDSL_TA_LAST) begin
            cnt_r   <= 4'd0;
            state_r <= MDSL_DATA;
          end
        end
        MDSL_DATA: begin
          cnt_r <= cnt_r + 4'd1;
          if (cnt_r == `MDSL_DATA_LAST) begin
            cnt_r   <= 4'd0;
            state_r <= MDSL_PRE;
          end
        end
        default: begin
          state_r <= MDSL_PRE;
        end
      endcase
    end
  end

  // header decode at the last reg field bit
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rd_r      <= 1'b0;
      ext_r     <= 1'b0;
      hit_r     <= 1'b0;
      sw_addr_r <= 8'h00;
      phy_idx_r <= 6'h00;
    end else if (rise && state_r == MDSL_HDR && cnt_r == `MDSL_HDR_LAST) begin
      rd_r  <= (hdr_nxt[11:10] == `MDSL_OP_RD);
      ext_r <= is_ext(hdr_nxt[11:10], hdr_nxt[9:5]);
      sw_addr_r <= {hdr_nxt[9], hdr_nxt[8], hdr_nxt[5], hdr_nxt[4:0]};
      phy_idx_r <= {port_w[2:0], slot_w[2:0]};
      if (is_ext(hdr_nxt[11:10], hdr_nxt[9:5])) begin
        hit_r <= 1'b1;
      end else begin
        // unknown phy addresses stay silent so other phys may answer
        hit_r <= (hdr_nxt[11:10] == `MDSL_OP_RD || hdr_nxt[11:10] == `MDSL_OP_WR)
               && hdr_nxt[9:5] >= `MDSL_PORT_FIRST && hdr_nxt[9:5] <= `MDSL_PORT_LAST
               && slot_w[3];
      end
    end
  end

  // data line: read drive changes right after a rising edge
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      MDIO_O  <= 1'b1;
      MDIO_OE <= 1'b0;
      sh_r    <= 16'h0000;
    end else if (rise) begin
      if (state_r == MDSL_TA && cnt_r == 4'd0 && rd_r && hit_r) begin
        MDIO_OE <= 1'b1;
        MDIO_O  <= 1'b0;
        sh_r    <= ext_r ? {8'h00, sw_rdata} : phy_rdata;
      end else if (state_r == MDSL_TA && cnt_r == `MDSL_TA_LAST && MDIO_OE) begin
        MDIO_O <= sh_r[15];
        sh_r   <= {sh_r[14:0], 1'b0};
      end else if (state_r == MDSL_DATA && MDIO_OE) begin
        if (cnt_r == `MDSL_DATA_LAST) begin
          MDIO_OE <= 1'b0;
          MDIO_O  <= 1'b1;
        end else begin
          MDIO_O <= sh_r[15];
          sh_r   <= {sh_r[14:0], 1'b0};
        end
      end else if (state_r == MDSL_DATA) begin
        sh_r <= wr_nxt;
      end
    end
  end

  // write strobes on the last data bit
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      SW_WR_STB   <= 1'b0;
      SW_WR_ADDR  <= 8'h00;
      SW_WR_DATA  <= 8'h00;
      phy_we_r    <= 1'b0;
      phy_wdata_r <= 16'h0000;
    end else begin
      SW_WR_STB <= 1'b0;
      phy_we_r  <= 1'b0;
      if (rise && state_r == MDSL_DATA && cnt_r == `MDSL_DATA_LAST && hit_r && !rd_r) begin
        if (ext_r) begin
          SW_WR_STB  <= 1'b1;
          SW_WR_ADDR <= sw_addr_r;
          SW_WR_DATA <= wr_nxt[7:0];
        end else begin
          phy_we_r    <= 1'b1;
          phy_wdata_r <= wr_nxt;
        end
      end
    end
  end

  // storage read address follows decode; switch write address follows the strobe
  mdsl_regfile u_regs (
    .clk       (REF_CLK),
    .sw_we     (SW_WR_STB),
    .sw_addr   (SW_WR_STB ? SW_WR_ADDR : sw_addr_r),
    .sw_wdata  (SW_WR_DATA),
    .sw_rdata  (sw_rdata),
    .phy_we    (phy_we_r),
    .phy_idx   (phy_idx_r),
    .phy_wdata (phy_wdata_r),
    .phy_rdata (phy_rdata)
  );

endmodule

// >>> mdsl_consts.svh
// Purpose: constants of the management-frame slave
// Assumes: included by its bare name
// Notes:   timing figures are for reference and derived counts
`ifndef MDSL_CONSTS_SVH
`define MDSL_CONSTS_SVH

`define MDSL_PRE_ONES      6'd32
`define MDSL_OP_RD         2'b10
`define MDSL_OP_WR         2'b01
`define MDSL_EXT_SEL       2'b11
`define MDSL_HDR_LAST      4'd11
`define MDSL_TA_LAST       4'd1
`define MDSL_DATA_LAST     4'd15
`define MDSL_PORT_FIRST    5'd1
`define MDSL_PORT_LAST     5'd5
`define MDSL_STD_LAST      5'h05
`define MDSL_REG_1D        5'h1d
`define MDSL_REG_1F        5'h1f
`define MDSL_IDX_1D        3'd6
`define MDSL_IDX_1F        3'd7
`define MDSL_FAMILY_ADDR   8'h00
`define MDSL_FAMILY_VAL    8'h5a
`define MDSL_REF_HZ        50000000
`define MDSL_MDC_MAX_HZ    10000000
`define MDSL_MDC_MIN_CYC   (`MDSL_REF_HZ / `MDSL_MDC_MAX_HZ)

`endif

// >>> mdsl_pkg.sv
// Purpose: types of the management-frame slave
// Assumes: nothing
// Notes:   state codes written out
package mdsl_pkg;

  typedef enum logic [2:0] {
    MDSL_PRE  = 3'b000,
    MDSL_SOF  = 3'b001,
    MDSL_HDR  = 3'b010,
    MDSL_TA   = 3'b011,
    MDSL_DATA = 3'b100
  } mdsl_state_e;

  typedef logic [7:0]  mdsl_byte_t;
  typedef logic [15:0] mdsl_word_t;

endpackage

// >>> mdsl_regfile.sv
// Purpose: switch register space and per-port phy register storage
// Assumes: writes arrive as single-cycle strobes
// Notes:   arrays carry no reset; contents belong to the switch datapath
`timescale 1ns/1ps
`include "mdsl_consts.svh"

module mdsl_regfile
  import mdsl_pkg::*;
#(
  parameter mdsl_byte_t FAMILY_ID = `MDSL_FAMILY_VAL  // arbitrary value
) (
  input  wire logic       clk,
  input  wire logic       sw_we,
  input  wire logic [7:0] sw_addr,
  input  wire mdsl_byte_t sw_wdata,
  output mdsl_byte_t      sw_rdata,
  input  wire logic       phy_we,
  input  wire logic [5:0] phy_idx,
  input  wire mdsl_word_t phy_wdata,
  output mdsl_word_t      phy_rdata
);

  mdsl_byte_t sw_mem [0:255];
  mdsl_word_t phy_mem [0:39];

  always_ff @(posedge clk) begin
    if (sw_we) begin
      sw_mem[sw_addr] <= sw_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (phy_we) begin
      phy_mem[phy_idx] <= phy_wdata;
    end
  end

  // family id is read-only; the slot is still writable but never shown
  assign sw_rdata  = (sw_addr == `MDSL_FAMILY_ADDR) ? FAMILY_ID : sw_mem[sw_addr];
  assign phy_rdata = phy_mem[phy_idx];

endmodule

// >>> mdsl_slave_props.sv
// Purpose: link and strobe checks for mdsl_slave
// Assumes: link bits last at least 5 clocks
// Notes:   bound at file foot
`timescale 1ns/1ps
module mdsl_slave_props
  import mdsl_pkg::*;
(
  input wire logic       REF_CLK,
  input wire logic       RST,
  input wire logic       MDIO_O,
  input wire logic       MDIO_OE,
  input wire logic       SW_WR_STB,
  input wire logic [7:0] SW_WR_ADDR,
  input wire mdsl_byte_t SW_WR_DATA
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  chk_stb_single: assert property (SW_WR_STB |=> !SW_WR_STB)
    else $error("long strobe");
  chk_addr_held: assert property ($changed(SW_WR_ADDR) |-> SW_WR_STB)
    else $error("addr moved");
  chk_data_held: assert property ($changed(SW_WR_DATA) |-> SW_WR_STB)
    else $error("data moved");
  chk_write_quiet: assert property (SW_WR_STB |-> !MDIO_OE)
    else $error("drive on write");
  chk_ta_zero: assert property ($rose(MDIO_OE) |-> !MDIO_O)
    else $error("ta not zero");
  chk_release_high: assert property ($fell(MDIO_OE) |-> MDIO_O)
    else $error("low after release");
  chk_drive_span: assert property ($rose(MDIO_OE) |=> MDIO_OE [*8])
    else $error("short read");
  chk_bit_stands: assert property (MDIO_OE && $changed(MDIO_O) |=> $stable(MDIO_O) [*4])
    else $error("bit too short");
endmodule
bind mdsl_slave mdsl_slave_props u_props (.REF_CLK, .RST, .MDIO_O, .MDIO_OE, .SW_WR_STB,
  .SW_WR_ADDR, .SW_WR_DATA);

// >>> mdsl_ctrl.sv
// Purpose: management controller model
// Assumes: 160 ns link clock, line pulled up
// Notes:   clock idles low between frames
`timescale 1ns/1ps
module mdsl_ctrl (
  output logic      mdc,
  output logic      mdio_i,
  input  wire logic mdio_o,
  input  wire logic mdio_oe
);
  logic drv = 1'b1;
  logic drv_en = 1'b0;
  initial mdc = 1'b0;
  // pull-up when nobody drives
  assign mdio_i = mdio_oe ? mdio_o : (drv_en ? drv : 1'b1);
  // data held 120 ns past the rise: slave samples through a synchroniser
  task automatic put(input logic b, input logic en, output logic s);
    drv = b;
    drv_en = en;
    #40 s = mdio_i;
    mdc = 1'b1;
    #80 mdc = 1'b0;
    #40;
  endtask
  task automatic frame(input int pre, input logic [1:0] op, input logic [9:0] ad,
                       input logic [15:0] wd, output logic [16:0] rd);
    logic s;
    logic rdop;
    logic [13:0] h;
    h = {2'b01, op, ad};
    rdop = (op == 2'b10);
    for (int i = 0; i < pre; i++) put(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) put(h[i], 1'b1, s);
    put(1'b1, !rdop, s);
    put(1'b0, !rdop, rd[16]);
    for (int i = 15; i >= 0; i--) put(wd[i], !rdop, rd[i]);
    drv_en = 1'b0;
  endtask
endmodule

// >>> mdsl_slave_bench.sv
// Purpose: self-checking bench of mdsl_slave
// Assumes: fixed seed, link clock 160 ns
// Notes:   phy storage checked by read-back only
`timescale 1ns/1ps
`include "mdsl_consts.svh"
module mdsl_slave_bench;
  logic        REF_CLK = 1'b0;
  logic        RST = 1'b1;
  logic        MDC, MDIO_I, MDIO_O, MDIO_OE, SW_WR_STB;
  logic [7:0]  SW_WR_ADDR, SW_WR_DATA, a;
  logic [15:0] d;
  logic [16:0] rd;
  int          mismatches = 0, cmp_count = 0, stb_cnt = 0, n, seed = 96944;
  always #10 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) if (SW_WR_STB === 1'b1) stb_cnt <= stb_cnt + 1;
  mdsl_slave i_dut (.REF_CLK, .RST, .MDC, .MDIO_I, .MDIO_O, .MDIO_OE, .SW_WR_STB,
    .SW_WR_ADDR, .SW_WR_DATA);
  mdsl_ctrl u_ctrl (.mdc(MDC), .mdio_i(MDIO_I), .mdio_o(MDIO_O), .mdio_oe(MDIO_OE));
  function automatic logic [9:0] ext(input logic [7:0] x);
    return {x[7:6], 2'b11, x[5:0]};
  endfunction
  // extended read: zero turnaround bit, zero upper byte, register byte low
  function automatic logic [16:0] exp_ext(input logic [7:0] b);
    return {9'h000, b};
  endfunction
  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic xf(input int pre, input logic [1:0] op, input logic [9:0] ad,
                    input logic [15:0] wd);
    n = stb_cnt;
    u_ctrl.frame(pre, op, ad, wd, rd);
    repeat (8) @(negedge REF_CLK);
  endtask
  initial begin
    #1000000;
    mismatches++;
    complete_run();
  end
  initial begin
    repeat (6) @(negedge REF_CLK);
    RST = 1'b0;
    repeat (5) @(negedge REF_CLK);
    xf(32, 2'b10, ext(8'h00), 16'h0);
    check(rd, exp_ext(`MDSL_FAMILY_VAL));
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 8'hff : (i == 1) ? 8'h01 : 8'($random(seed));
      if (a == 8'h00) a = 8'h80;
      d = 16'($random(seed));
      xf(32 + i, 2'b01, ext(a), d);
      check(17'(stb_cnt - n), 17'h00001);
      check({1'b0, SW_WR_ADDR, SW_WR_DATA}, {1'b0, a, d[7:0]});
      xf(32, 2'b10, ext(a), 16'hffff);
      check(rd, exp_ext(d[7:0]));
    end
    for (int i = 0; i < 8; i++) begin
      a = (i < 6) ? 8'(i) : (i == 6) ? 8'h1d : 8'h1f;
      d = 16'($random(seed));
      xf(32, 2'b01, {5'(1 + i % 5), a[4:0]}, d);
      check(17'(stb_cnt - n), 17'h00000);
      xf(32, 2'b10, {5'(1 + i % 5), a[4:0]}, 16'h0);
      check(rd, {1'b0, d});
    end
    // mid-run reset between frames: outputs back to idle, last write cleared
    RST = 1'b1;
    @(negedge REF_CLK);
    check({14'h0000, MDIO_OE, MDIO_O, SW_WR_STB}, 17'h00002);
    check({1'b0, SW_WR_ADDR, SW_WR_DATA}, 17'h00000);
    RST = 1'b0;
    repeat (5) @(negedge REF_CLK);
    xf(32, 2'b10, {5'h01, 5'h10}, 16'h0);
    check(rd, 17'h1ffff);
    xf(32, 2'b10, {5'h00, 5'h00}, 16'h0);
    check(rd, 17'h1ffff);
    xf(31, 2'b10, ext(8'h00), 16'h0);
    check(rd, 17'h1ffff);
    xf(32, 2'b00, ext(8'h10), 16'h00ff);
    check(17'(stb_cnt - n), 17'h00000);
    complete_run();
  end
endmodule
